//--- design/hmd_pkg.sv
// shared constants and types for the host memory dma port
package hmd_pkg;
  // ----------------------------------------
  // link widths
  // ----------------------------------------
  localparam int AD_W = 16;
  localparam int ADDR_W = 14;
  localparam int PM_W = 24;
  localparam int MEM_DEPTH = 16384;
  localparam int PIN_W = 20;

  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int OVL_FLAG_BIT = 15;
  localparam int MEM_SEL_BIT = 14;
  localparam int SRO_BIT = 14;
  localparam logic [7:0] OVL_ZERO_MASK = 8'h7f;

  // ----------------------------------------
  // core data space locations
  // ----------------------------------------
  localparam logic [13:0] CTRL_BASE = 14'h3fe0;
  localparam logic [13:0] OVL_LOC = 14'h3fe0;
  localparam logic [13:0] START_LOC = 14'h3fe1;
  localparam logic [13:0] CFG_LOC = 14'h3fe7;

  // ----------------------------------------
  // boot and reset values
  // ----------------------------------------
  localparam logic [2:0] BOOT_PORT_MODE = 3'h5;
  localparam logic [PIN_W-1:0] PINS_IDLE = 20'hb_0000;
  localparam logic [15:0] OVL_RESET = 16'h0000;

  // ----------------------------------------
  // host controller register offsets
  // ----------------------------------------
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [7:0] HREG_RDATA = 8'h08;
  localparam int CMD_KIND_LSB = 16;

  typedef enum logic [1:0] {
    HMD_NONE,
    HMD_LATCH,
    HMD_WRITE,
    HMD_READ
  } hmd_kind_e;
endpackage

//--- design/hmd_if.sv
// pin bundle between the host controller and the memory port
`timescale 1ns/1ns
`default_nettype none
interface hmd_if;
  logic [15:0] host_ad_o;
  logic host_ad_oe;
  logic [15:0] dev_ad_o;
  logic dev_ad_oe;
  logic [15:0] host_addr_data_bus;
  logic port_select_n;
  logic address_latch_strobe;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic port_acknowledge;

  // resolved shared bus level
  assign host_addr_data_bus = dev_ad_oe ? dev_ad_o : (host_ad_oe ? host_ad_o : 16'h0000);

  modport dev (
    input host_addr_data_bus, port_select_n, address_latch_strobe,
    input host_read_strobe_n, host_write_strobe_n,
    output dev_ad_o, dev_ad_oe, port_acknowledge
  );
  modport hst (
    input host_addr_data_bus, port_acknowledge,
    output host_ad_o, host_ad_oe, port_select_n, address_latch_strobe,
    output host_read_strobe_n, host_write_strobe_n
  );
endinterface
`default_nettype wire

//--- design/hmd_device.sv
// device end of the host memory dma port with on-chip memories
//
// Behaviour
// RQ1: one core cycle stolen per word; the code steals one per read or write transaction (none for a latch), so two per program word
// RQ2: host cannot write control registers
// RQ3: bit15 set: low byte is overlay
// RQ4: bit15 clear: address and memory select
// RQ5: host waits acknowledge before latching
// RQ6: host checks acknowledge before next access
// RQ7: 16-bit shared bus, 24-bit program words
// RQ8: strobes asynchronous, accepted while running
// RQ9: address increments after each transaction; for program memory the code increments only after the second half
// RQ10: host drives address plus select bit
// RQ11: latch on falling address strobe edge
// RQ12: one sync cycle, one access cycle
// RQ13: start address never read back
// RQ14: overlay visible at core location 0x3fe0
// RQ15: config bit14 selects short-read mode
// RQ16: software writes only valid overlay values
// RQ17: core may write start address latch
// RQ18: mode pins 101 select port boot
// RQ19: hold execution until program word 0
// RQ20: program word as two bus transactions
// RQ21: acknowledge low until access finished
`timescale 1ns/1ns
`default_nettype none
module hmd_device (
  input wire logic pclk,
  input wire logic presetn,
  hmd_if.dev link,
  input wire logic [2:0] boot_mode_pins,
  input wire logic core_we,
  input wire logic core_re,
  input wire logic [13:0] core_addr,
  input wire logic [15:0] core_wdata,
  output logic [15:0] core_rdata,
  output logic core_stall,
  output logic core_hold,
  output logic core_start,
  output logic [3:0] program_bank_window_select,
  output logic [3:0] data_bank_window_select,
  output logic short_read_only
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    D_IDLE,
    D_LATCH,
    D_SYNC,
    D_ACCESS,
    D_HOLD
  } hmd_dev_e;

  typedef struct packed {
    hmd_dev_e st;
    logic [19:0] s1;
    logic [19:0] s2;
    logic [19:0] s3;
    logic [19:0] f;
    logic ack;
    logic [15:0] ad_o;
    logic ad_oe;
    logic is_rd;
    logic [13:0] addr;
    logic is_pm;
    logic half;
    logic [15:0] hold;
    logic [15:0] ovl;
    logic sro;
    logic boot_chk;
    logic boot_wait;
    logic start;
    logic stall;
    logic [15:0] core_rdata;
  } hmd_dev_s;

  hmd_dev_s r;
  hmd_dev_s next_r;
  logic [23:0] pm_mem [0:hmd_pkg::MEM_DEPTH-1];
  logic [15:0] dm_mem [0:hmd_pkg::MEM_DEPTH-1];
  logic pm_we;
  logic dm_we;
  logic [23:0] pm_wdata;
  logic [15:0] dm_wdata;
  logic sel_n;
  logic als;
  logic rd_n;
  logic wr_n;
  logic [15:0] ad;

  always_comb begin
    {sel_n, als, rd_n, wr_n, ad} = r.f;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    pm_we = 1'b0;
    dm_we = 1'b0;
    // RQ7 wide word from halves
    pm_wdata = {r.hold, ad[7:0]};
    dm_wdata = ad;
    next_r.stall = 1'b0;
    next_r.start = 1'b0;
    // RQ8 three-stage pin sync
    next_r.s1 = {link.port_select_n, link.address_latch_strobe, link.host_read_strobe_n,
                 link.host_write_strobe_n, link.host_addr_data_bus};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.f = r.s3;
    end
    // RQ18 boot mode capture
    if (!r.boot_chk) begin
      next_r.boot_chk = 1'b1;
      next_r.boot_wait = (boot_mode_pins == hmd_pkg::BOOT_PORT_MODE);
    end
    // RQ17 core side control writes
    if (core_we) begin
      if (core_addr == hmd_pkg::OVL_LOC) begin
        next_r.ovl = core_wdata;
      end else if (core_addr == hmd_pkg::CFG_LOC) begin
        next_r.sro = core_wdata[hmd_pkg::SRO_BIT];
      end else if (core_addr == hmd_pkg::START_LOC) begin
        if (core_wdata[hmd_pkg::OVL_FLAG_BIT]) begin
          next_r.ovl = {8'h00, core_wdata[7:0]};
        end else begin
          next_r.addr = core_wdata[13:0];
          next_r.is_pm = core_wdata[hmd_pkg::MEM_SEL_BIT];
          next_r.half = 1'b0;
        end
      end
    end
    // RQ14 overlay and config read by core
    if (core_re) begin
      if (core_addr == hmd_pkg::OVL_LOC) begin
        next_r.core_rdata = r.ovl;
      end else if (core_addr == hmd_pkg::CFG_LOC) begin
        next_r.core_rdata = {1'b0, r.sro, 14'h0000};
      end else begin
        next_r.core_rdata = 16'h0000;
      end
    end
    case (r.st)
      D_IDLE: begin
        if (!sel_n && als) begin
          // RQ21 busy during latch
          next_r.ack = 1'b0;
          next_r.st = D_LATCH;
        end else if (!sel_n && (!rd_n || !wr_n)) begin
          // RQ12 synchronisation cycle
          next_r.ack = 1'b0;
          next_r.is_rd = !rd_n;
          next_r.st = D_SYNC;
        end
      end
      D_LATCH: begin
        if (!als || sel_n) begin
          // RQ11 capture on falling strobe
          if (ad[hmd_pkg::OVL_FLAG_BIT]) begin
            // RQ3 overlay selection
            next_r.ovl = {8'h00, ad[7:0]};
          end else begin
            // RQ4 start address and memory
            next_r.addr = ad[13:0];
            next_r.is_pm = ad[hmd_pkg::MEM_SEL_BIT];
            next_r.half = 1'b0;
          end
          next_r.ack = 1'b1;
          next_r.st = D_HOLD;
        end
      end
      D_SYNC: begin
        next_r.st = D_ACCESS;
      end
      D_ACCESS: begin
        // RQ1 single stolen core cycle
        next_r.stall = 1'b1;
        next_r.ack = 1'b1;
        next_r.st = D_HOLD;
        if (r.is_pm) begin
          // RQ20 upper half then lower byte
          if (!r.half) begin
            next_r.half = 1'b1;
            if (r.is_rd) begin
              next_r.ad_o = pm_mem[r.addr][23:8];
              next_r.hold = {8'h00, pm_mem[r.addr][7:0]};
            end else begin
              next_r.hold = ad;
            end
          end else begin
            next_r.half = 1'b0;
            // RQ9 advance after full word
            next_r.addr = r.addr + 14'h0001;
            if (r.is_rd) begin
              next_r.ad_o = r.hold;
            end else begin
              pm_we = 1'b1;
              if (r.addr == 14'h0000) begin
                // RQ19 release execution
                next_r.boot_wait = 1'b0;
                next_r.start = r.boot_wait;
              end
            end
          end
        end else begin
          next_r.addr = r.addr + 14'h0001;
          if (r.is_rd) begin
            next_r.ad_o = dm_mem[r.addr];
          end else begin
            // RQ2 control region is not writable
            dm_we = (r.addr < hmd_pkg::CTRL_BASE);
          end
        end
        next_r.ad_oe = r.is_rd;
      end
      D_HOLD: begin
        if (sel_n || (rd_n && wr_n && !als)) begin
          next_r.ad_oe = 1'b0;
          next_r.st = D_IDLE;
        end
      end
      default: begin
        next_r.st = D_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers and memories
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= D_IDLE;
      r.s1 <= hmd_pkg::PINS_IDLE;
      r.s2 <= hmd_pkg::PINS_IDLE;
      r.s3 <= hmd_pkg::PINS_IDLE;
      r.f <= hmd_pkg::PINS_IDLE;
      r.ovl <= hmd_pkg::OVL_RESET;
      r.ack <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge pclk) begin
    if (pm_we) begin
      pm_mem[r.addr] <= pm_wdata;
    end
    if (dm_we) begin
      dm_mem[r.addr] <= dm_wdata;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // RQ13 read data path never carries the latch
  assign link.dev_ad_o = r.ad_o;
  assign link.dev_ad_oe = r.ad_oe;
  assign link.port_acknowledge = r.ack;
  assign core_rdata = r.core_rdata;
  assign core_stall = r.stall;
  assign core_hold = r.boot_wait;
  assign core_start = r.start;
  assign program_bank_window_select = r.ovl[3:0];
  assign data_bank_window_select = r.ovl[7:4];
  // RQ15 short-read mode select
  assign short_read_only = r.sro;
endmodule
`default_nettype wire

//--- design/hmd_host.sv
// host end: apb-programmed controller driving the memory port pins
`timescale 1ns/1ns
`default_nettype none
module hmd_host (
  input wire logic pclk,
  input wire logic presetn,
  hmd_if.hst link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [2:0] {
    H_IDLE,
    H_WAIT_RDY,
    H_WAIT_LOW,
    H_WAIT_HIGH,
    H_DONE
  } hmd_host_e;

  typedef struct packed {
    hmd_host_e st;
    logic [16:0] s1;
    logic [16:0] s2;
    logic [16:0] s3;
    logic [16:0] f;
    hmd_pkg::hmd_kind_e kind;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;
    logic sel_n;
    logic als;
    logic rd_n;
    logic wr_n;
    logic ad_oe;
    logic [31:0] prdata;
    logic pready;
  } hmd_host_s;

  hmd_host_s r;
  hmd_host_s next_r;
  logic ack;
  logic [15:0] ad;
  logic acc;

  always_comb begin
    {ack, ad} = r.f;
    acc = psel && penable && r.pready;
  end

  always_comb begin
    next_r = r;
    next_r.s1 = {link.port_acknowledge, link.host_addr_data_bus};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.f = r.s3;
    end
    // ----------------------------------------
    // apb slave, one wait-free access phase
    // ----------------------------------------
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      case (paddr)
        hmd_pkg::HREG_STATUS: next_r.prdata = {30'h0000_0000, r.done, r.st != H_IDLE};
        hmd_pkg::HREG_RDATA: next_r.prdata = {16'h0000, r.rdata};
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite && paddr == hmd_pkg::HREG_CMD && r.st == H_IDLE &&
        pwdata[17:16] != 2'h0) begin
      next_r.kind = hmd_pkg::hmd_kind_e'(pwdata[17:16]);
      next_r.wdata = pwdata[15:0];
      next_r.done = 1'b0;
      next_r.st = H_WAIT_RDY;
    end
    // ----------------------------------------
    // pin sequencer
    // ----------------------------------------
    case (r.st)
      H_IDLE: begin
      end
      H_WAIT_RDY: begin
        // RQ5 RQ6 wait until device not busy
        if (ack) begin
          next_r.sel_n = 1'b0;
          next_r.ad_oe = (r.kind != hmd_pkg::HMD_READ);
          // RQ10 address word on the bus
          next_r.als = (r.kind == hmd_pkg::HMD_LATCH);
          next_r.wr_n = (r.kind != hmd_pkg::HMD_WRITE);
          next_r.rd_n = (r.kind != hmd_pkg::HMD_READ);
          next_r.st = H_WAIT_LOW;
        end
      end
      H_WAIT_LOW: begin
        if (!ack) begin
          // falling strobe latches the word
          next_r.als = 1'b0;
          next_r.st = H_WAIT_HIGH;
        end
      end
      H_WAIT_HIGH: begin
        if (ack) begin
          next_r.rdata = (r.kind == hmd_pkg::HMD_READ) ? ad : r.rdata;
          next_r.sel_n = 1'b1;
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.ad_oe = 1'b0;
          next_r.st = H_DONE;
        end
      end
      H_DONE: begin
        next_r.done = 1'b1;
        next_r.st = H_IDLE;
      end
      default: begin
        next_r.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= H_IDLE;
      r.kind <= hmd_pkg::HMD_NONE;
      r.sel_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.host_ad_o = r.wdata;
  assign link.host_ad_oe = r.ad_oe;
  assign link.port_select_n = r.sel_n;
  assign link.address_latch_strobe = r.als;
  assign link.host_read_strobe_n = r.rd_n;
  assign link.host_write_strobe_n = r.wr_n;
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

//--- tb/hmd_checker.sv
// concurrent checks on the pins between host controller and memory port
`timescale 1ns/1ns
`default_nettype none
module hmd_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] host_addr_data_bus,
  input wire logic port_select_n,
  input wire logic address_latch_strobe,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic port_acknowledge,
  input wire logic dev_ad_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // acknowledge handshake
  // ----------------------------------------
  a_ack_fall_write: assert property ($fell(host_write_strobe_n) && !port_select_n |-> ##[1:8] !port_acknowledge)
    else $error("ack stayed high after write request");
  a_ack_fall_read: assert property ($fell(host_read_strobe_n) && !port_select_n |-> ##[1:8] !port_acknowledge)
    else $error("ack stayed high after read request");
  a_ack_fall_latch: assert property ($rose(address_latch_strobe) && !port_select_n |-> ##[1:8] !port_acknowledge)
    else $error("ack stayed high after latch request");
  a_ack_return: assert property ($fell(port_acknowledge) |-> ##[1:16] port_acknowledge)
    else $error("ack stayed low too long");
  a_ack_hold: assert property ($rose(port_acknowledge) |-> port_acknowledge[*2])
    else $error("ack high for a single cycle");

  // ----------------------------------------
  // read data drive
  // ----------------------------------------
  a_read_drive: assert property ($rose(dev_ad_oe) |-> port_acknowledge && !host_read_strobe_n)
    else $error("bus driven outside a read");
  a_oe_with_ack: assert property (dev_ad_oe && !host_read_strobe_n |-> port_acknowledge)
    else $error("read data driven while busy");
  a_oe_release: assert property ($rose(host_read_strobe_n) |-> ##[1:6] !dev_ad_oe)
    else $error("bus still driven after read release");

  // ----------------------------------------
  // host side ordering
  // ----------------------------------------
  a_req_when_ready: assert property ($fell(port_select_n) |-> port_acknowledge)
    else $error("request raised while port busy");
  a_release_after_ack: assert property ($rose(port_select_n) |-> port_acknowledge)
    else $error("request released before access finished");
  a_ovl_upper_zero: assert property (address_latch_strobe && !port_select_n && host_addr_data_bus[15] |-> host_addr_data_bus[14:8] == 7'h00)
    else $error("overlay word with nonzero upper bits");
endmodule
`default_nettype wire

//--- tb/test_host_memory_dma_port.sv
// self-checking bench joining host controller and memory port
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module test_host_memory_dma_port;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic core_we = 0, core_re = 0, core_stall, core_hold, core_start, sro, started = 0;
  logic [13:0] core_addr = 0;
  logic [15:0] core_wdata = 0, core_rdata, d;
  logic [3:0] pbws, dbws;
  logic [2:0] boot_pins = 3'h5;
  int bad_count = 0, checks = 0, cyc = 0, stalls = 0, s0;

  always #4 pclk = ~pclk;

  hmd_if hmd_if_inst ();
  hmd_device hmd_device_inst (.pclk(pclk), .presetn(presetn), .link(hmd_if_inst.dev),
    .boot_mode_pins(boot_pins), .core_we(core_we), .core_re(core_re), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata), .core_stall(core_stall),
    .core_hold(core_hold), .core_start(core_start), .program_bank_window_select(pbws),
    .data_bank_window_select(dbws), .short_read_only(sro));
  hmd_host hmd_host_inst (.pclk(pclk), .presetn(presetn), .link(hmd_if_inst.hst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  hmd_checker hmd_checker_inst (.pclk(pclk), .presetn(presetn),
    .host_addr_data_bus(hmd_if_inst.host_addr_data_bus),
    .port_select_n(hmd_if_inst.port_select_n),
    .address_latch_strobe(hmd_if_inst.address_latch_strobe),
    .host_read_strobe_n(hmd_if_inst.host_read_strobe_n),
    .host_write_strobe_n(hmd_if_inst.host_write_strobe_n),
    .port_acknowledge(hmd_if_inst.port_acknowledge), .dev_ad_oe(hmd_if_inst.dev_ad_oe));

  // ----------------------------------------
  // monitors and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (core_stall === 1'b1) stalls++;
    if (core_start === 1'b1) started = 1;
    if (cyc > 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic cmd(input logic [1:0] k, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] r;
    int n;
    apb(1, 8'h00, {14'h0000, k, wd}, r);
    n = 0;
    do begin apb(0, 8'h04, 32'h0000_0000, r); n++; end while (r[1] !== 1'b1 && n < 300);
    `CHK(r[1], 1'b1)
    apb(0, 8'h08, 32'h0000_0000, r);
    rd = r[15:0];
  endtask

  task automatic core_acc(input logic w, input logic [13:0] a, input logic [15:0] wd);
    @(posedge pclk);
    core_we <= w; core_re <= !w; core_addr <= a; core_wdata <= wd;
    @(posedge pclk);
    core_we <= 0; core_re <= 0;
    @(negedge pclk);
    d = core_rdata;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot();
    `CHK(hmd_if_inst.port_acknowledge, 1'b1)
    `CHK(core_hold, 1'b1)
    cmd(1, 16'h4000, d);
    cmd(2, 16'h1234, d);
    `CHK(core_hold, 1'b1)
    cmd(2, 16'h0056, d);
    `CHK(core_hold, 1'b0)
    `CHK(started, 1'b1)
  endtask

  task automatic t_dm();
    cmd(1, 16'h0100, d);
    s0 = stalls;
    cmd(2, 16'h1234, d);
    cmd(2, 16'habcd, d);
    cmd(1, 16'h0100, d);
    cmd(3, 16'h0000, d);
    `CHK(d, 16'h1234)
    cmd(3, 16'h0000, d);
    `CHK(d, 16'habcd)
    `CHK(stalls - s0, 4)
  endtask

  task automatic t_pm();
    cmd(1, 16'h4200, d);
    cmd(2, 16'ha5c3, d);
    cmd(2, 16'h0077, d);
    cmd(2, 16'h1111, d);
    cmd(2, 16'h0022, d);
    cmd(1, 16'h4200, d);
    cmd(3, 16'h0000, d);
    `CHK(d, 16'ha5c3)
    cmd(3, 16'h0000, d);
    `CHK(d, 16'h0077)
    cmd(3, 16'h0000, d);
    `CHK(d, 16'h1111)
    cmd(1, 16'h4000, d);
    cmd(3, 16'h0000, d);
    `CHK(d, 16'h1234)
  endtask

  task automatic t_ctrl();
    logic [31:0] r;
    cmd(1, 16'h3fe0, d);
    cmd(2, 16'h00ff, d);
    core_acc(0, hmd_pkg::OVL_LOC, 16'h0000);
    `CHK(d, 16'h0000)
    cmd(1, 16'h8054, d);
    core_acc(0, hmd_pkg::OVL_LOC, 16'h0000);
    `CHK(d, 16'h0054)
    `CHK(pbws, 4'h4)
    `CHK(dbws, 4'h5)
    apb(0, 8'h0c, 32'h0000_0000, r);
    `CHK(r, 32'h0000_0000)
    `CHK(pslverr, 1'b0)
  endtask

  task automatic t_core();
    core_acc(1, hmd_pkg::CFG_LOC, 16'h4000);
    `CHK(sro, 1'b1)
    core_acc(0, hmd_pkg::CFG_LOC, 16'h0000);
    `CHK(d, 16'h4000)
    core_acc(1, hmd_pkg::CFG_LOC, 16'h0000);
    `CHK(sro, 1'b0)
    core_acc(1, hmd_pkg::START_LOC, 16'h0101);
    cmd(3, 16'h0000, d);
    `CHK(d, 16'habcd)
  endtask

  task automatic t_noboot();
    boot_pins <= 3'h0;
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
    `CHK(core_hold, 1'b0)
    `CHK(pbws, 4'h0)
    cmd(1, 16'h0100, d);
    cmd(3, 16'h0000, d);
    `CHK(d, 16'h1234)
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
    t_boot();
    t_dm();
    t_pm();
    t_ctrl();
    t_core();
    t_noboot();
    print_verdict();
  end
endmodule
`default_nettype wire
